// File: char_lcd_instruction_decoder.v
// char_lcd_instruction_decoder.v: command and data interpreter of a character
// display controller, with display memory, glyph memory and mode bits.
// assumes the host bus pins are synchronous to clk_i and enable is a level.
// Notes on behaviour
// - clear fills spaces, pointer zero, increment
// - home zeroes pointer and undoes shift
// - entry direction bit picks step sign
// - scroll bit shifts display on display memory writes
// - display control loads on, cursor, blink
// - shift moves cursor or window, no access
// - two-line cursor wraps line one to two
// - bus width bit picks nibble or byte
// - line count and font bits from function set
// - glyph address loads six bits, glyph target
// - display address loads seven bits
// - display address ranges per line mode
// - status read gives busy and pointer
// - busy high during internal operation
// - data write stores then steps pointer
// - data read returns byte then steps
// - byte mode uses all eight lines
// - nibble mode, high nibble first
// - nibble mode busy after second nibble
// - power-up clears and sets default modes
// - power-up busy for ten milliseconds
// - select low instruction, high data
// - enable strobe starts each transfer
// - busy times per instruction class
`timescale 1ns/1ps
`include "lcd_cmd_regs.vh"
module char_lcd_instruction_decoder #(
  parameter DD_DEPTH = 128,
  parameter CG_DEPTH = 64,
  parameter POWERUP_NS = `T_POWERUP_NS
) (
  input wire clk_i,
  input wire reset_i,
  input wire register_select_i,
  input wire read_write_i,
  input wire enable_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output wire data_oe_n_o,
  output wire busy_flag_o,
  output reg [6:0] memory_pointer_o,
  output reg display_on_o,
  output reg cursor_on_o,
  output reg blink_on_o,
  output reg two_line_o,
  output reg font_tall_o,
  output reg [6:0] display_shift_o
);
  // cycle counts, least times rounded up
  localparam integer LONG_CYC = (`T_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer INSTR_CYC = (`T_INSTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer DATA_CYC = (`T_DATA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer PWR_CYC = (POWERUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam TW = 20; // wide enough for 400000 cycles

  // sequencer states
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_CLEAR = 2'd1;

  reg [7:0] dd_mem [0:DD_DEPTH-1]; // display memory
  reg [7:0] cg_mem [0:CG_DEPTH-1]; // glyph memory
  reg [1:0] state_q; // idle or clearing
  reg [6:0] clr_idx_q; // clear sweep index
  reg en_q; // enable delayed, for edge detect
  reg nib_low_q; // next nibble is the low one
  reg [3:0] hi_nib_q; // stored high nibble
  reg inc_q; // entry direction, 1 increments
  reg scroll_q; // scroll on write
  reg bus8_q; // bus width select, 1 is byte wide
  reg glyph_sel_q; // data target, 1 is glyph memory
  reg tload; // busy timer load strobe
  reg [TW-1:0] tcount; // busy timer load value
  reg [7:0] cmd; // assembled byte
  reg strobe_done; // whole byte assembled this cycle
  reg [TW-1:0] pwr_q; // power-up busy span left
  wire busy_t;
  wire en_fall;
  wire is_write;

  assign en_fall = en_q & ~enable_i;
  assign is_write = ~read_write_i;
  // clear sweep and the power-up span also keep busy high
  // busy is high from reset release, so an early poll is harmless
  assign busy_flag_o = busy_t | (state_q == S_CLEAR) | (pwr_q != {TW{1'b0}});
  // pins driven only while the host reads and enable is high
  assign data_oe_n_o = ~(enable_i & read_write_i);

  // busy timer reloads per operation; one counter serves all classes
  lcd_busy_timer #(
    .W(TW)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(tload),
    .count_i(tcount),
    .busy_o(busy_t)
  );

  // opcode class from the highest set bit; zero byte decodes as clear class, long busy but nothing cleared
  function [2:0] op_class;
    input [7:0] b;
    begin
      if (b[7]) op_class = `OP_DDADDR;
      else if (b[6]) op_class = `OP_GLYPH;
      else if (b[5]) op_class = `OP_FUNC;
      else if (b[4]) op_class = `OP_SHIFT;
      else if (b[3]) op_class = `OP_DISP;
      else if (b[2]) op_class = `OP_ENTRY;
      else if (b[1]) op_class = `OP_HOME;
      else op_class = `OP_CLEAR;
    end
  endfunction

  // pointer step with line wrapping; used by data access and cursor shift
  function [6:0] step_ptr;
    input [6:0] p;
    input up;
    input two;
    input glyph;
    begin
      if (glyph) begin
        step_ptr = up ? {1'b0, p[5:0] + 6'h01} : {1'b0, p[5:0] - 6'h01};
      end else if (two) begin
        if (up) begin
          if (p == `LINE1_LAST) step_ptr = `LINE2_FIRST;
          else if (p == `LINE2_LAST) step_ptr = `ADDR_HOME;
          else step_ptr = p + 7'h01;
        end else begin
          if (p == `ADDR_HOME) step_ptr = `LINE2_LAST;
          else if (p == `LINE2_FIRST) step_ptr = `LINE1_LAST;
          else step_ptr = p - 7'h01;
        end
      end else begin
        if (up) step_ptr = (p == `ONE_LINE_LAST) ? `ADDR_HOME : p + 7'h01;
        else step_ptr = (p == `ADDR_HOME) ? `ONE_LINE_LAST : p - 7'h01;
      end
    end
  endfunction

  // byte assembly from one or two strobes
  // lines below the nibble are ignored in nibble mode
  always @* begin
    cmd = data_i;
    strobe_done = 1'b0;
    if (en_fall) begin
      if (bus8_q) begin
        strobe_done = 1'b1;
      end else if (nib_low_q) begin
        cmd = {hi_nib_q, data_i[7:4]};
        strobe_done = 1'b1;
      end
    end
  end

  // busy timer load per operation class
  always @* begin
    tload = 1'b0;
    tcount = {TW{1'b0}};
    if (reset_i) begin
      tload = 1'b0;
    end else if (strobe_done && register_select_i) begin
      tload = 1'b1;
      tcount = DATA_CYC[TW-1:0];
      // instructions while busy are dropped, not queued; the host must poll
    end else if (strobe_done && is_write && !busy_flag_o) begin
      tload = 1'b1;
      if (op_class(cmd) == `OP_HOME || op_class(cmd) == `OP_CLEAR)
        tcount = LONG_CYC[TW-1:0];
      else
        tcount = INSTR_CYC[TW-1:0];
    end
  end

  // power-up span counts down here so the busy timer stays generic
  // main control: decode, memories, pointer and modes
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= S_CLEAR;
      clr_idx_q <= 7'h00;
      en_q <= 1'b0;
      nib_low_q <= 1'b0;
      hi_nib_q <= 4'h0;
      inc_q <= 1'b1;
      scroll_q <= 1'b0;
      bus8_q <= 1'b1;
      glyph_sel_q <= 1'b0;
      memory_pointer_o <= `ADDR_HOME;
      display_on_o <= 1'b0;
      cursor_on_o <= 1'b0;
      blink_on_o <= 1'b0;
      two_line_o <= 1'b0;
      font_tall_o <= 1'b0;
      display_shift_o <= 7'h00;
      data_o <= 8'h00;
      pwr_q <= PWR_CYC[TW-1:0];
    end else begin
      en_q <= enable_i;
      if (pwr_q != {TW{1'b0}}) pwr_q <= pwr_q - {{(TW-1){1'b0}}, 1'b1};
      // nibble phase toggles on every strobe in nibble mode
      if (en_fall && !bus8_q) begin
        nib_low_q <= ~nib_low_q;
        if (!nib_low_q) hi_nib_q <= data_i[7:4];
      end
      // read data presented on enable rise; whole byte, or the first nibble
      // a second-nibble rise must not reload, or the low half would be lost
      if (enable_i && !en_q && read_write_i && (bus8_q || !nib_low_q)) begin
        if (!register_select_i)
          data_o <= {busy_flag_o, memory_pointer_o};
        else if (glyph_sel_q)
          data_o <= cg_mem[memory_pointer_o[5:0]];
        else
          data_o <= dd_mem[memory_pointer_o];
      end else if (enable_i && !en_q && read_write_i) begin
        // second nibble: low half moves onto the upper lines
        data_o <= {data_o[3:0], 4'h0};
      end
      if (state_q == S_CLEAR) begin
        dd_mem[clr_idx_q] <= `SPACE_CODE;
        clr_idx_q <= clr_idx_q + 7'h01;
        if (clr_idx_q == DD_DEPTH - 1) state_q <= S_IDLE;
      end else if (strobe_done && register_select_i) begin
        if (is_write) begin
          if (glyph_sel_q) cg_mem[memory_pointer_o[5:0]] <= cmd;
          else dd_mem[memory_pointer_o] <= cmd;
          if (scroll_q && !glyph_sel_q)
            display_shift_o <= inc_q ? display_shift_o - 7'h01 : display_shift_o + 7'h01;
        end
        memory_pointer_o <= step_ptr(memory_pointer_o, inc_q, two_line_o, glyph_sel_q);
      end else if (strobe_done && is_write && !busy_flag_o) begin
        case (op_class(cmd))
          `OP_CLEAR: begin
            if (cmd[0]) begin
              state_q <= S_CLEAR;
              clr_idx_q <= 7'h00;
              memory_pointer_o <= `ADDR_HOME;
              display_shift_o <= 7'h00;
              inc_q <= 1'b1;
              glyph_sel_q <= 1'b0;
            end
          end
          `OP_HOME: begin
            memory_pointer_o <= `ADDR_HOME;
            display_shift_o <= 7'h00;
            glyph_sel_q <= 1'b0;
          end
          `OP_ENTRY: begin
            inc_q <= cmd[`BIT_ID];
            scroll_q <= cmd[`BIT_SH];
          end
          `OP_DISP: begin
            display_on_o <= cmd[`BIT_DISP];
            cursor_on_o <= cmd[`BIT_CUR];
            blink_on_o <= cmd[`BIT_BLINK];
          end
          `OP_SHIFT: begin
            if (!cmd[`BIT_SC])
              memory_pointer_o <= step_ptr(memory_pointer_o, cmd[`BIT_RL], two_line_o,
                glyph_sel_q);
            else if (cmd[`BIT_RL])
              display_shift_o <= display_shift_o + 7'h01;
            else
              display_shift_o <= display_shift_o - 7'h01;
          end
          `OP_FUNC: begin
            bus8_q <= cmd[`BIT_DL];
            nib_low_q <= 1'b0;
            two_line_o <= cmd[`BIT_LINES];
            font_tall_o <= cmd[`BIT_FONT];
          end
          `OP_GLYPH: begin
            memory_pointer_o <= {1'b0, cmd[5:0]};
            glyph_sel_q <= 1'b1;
          end
          `OP_DDADDR: begin
            memory_pointer_o <= cmd[6:0];
            glyph_sel_q <= 1'b0;
          end
          default: begin
            glyph_sel_q <= glyph_sel_q;
          end
        endcase
      end
    end
  end

  // glyph memory has no reset; contents are undefined until written
  // the power-up span is a parameter so a bench can shorten it; the
  // default keeps busy for the full settling time after supply
endmodule

// File: host_bfm.sv
// host_bfm.sv: host processor on the parallel bus, byte or nibble wide.
// assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module host_bfm (
  input wire clk_i,
  input wire busy_i,
  input wire [7:0] rdata_i,
  output reg register_select_o = 1'b0,
  output reg read_write_o = 1'b0,
  output reg enable_o = 1'b0,
  output reg [7:0] data_o = 8'h00
);
  reg nib_q = 1'b0;  // host believes the bus is four bits wide
  reg [7:0] rd_q = 8'h00;  // last value read back
  integer slow = 0;  // extra enable-high cycles for a slow host
  // one strobe; qualifiers held until the falling edge is taken
  task strobe(input rs, input rw, input [7:0] d);
    begin
      @(posedge clk_i);
      #1 register_select_o = rs;
      read_write_o = rw;
      data_o = d;
      enable_o = 1'b1;
      repeat (2 + slow) @(posedge clk_i);
      #1 rd_q = rdata_i;
      enable_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 data_o = ~d;  // released lines show no stale value
    end
  endtask
  // wait out busy; the bench hang guard bounds it
  task idle;
    begin
      while (busy_i !== 1'b0) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  // a whole unit: one byte, or high nibble then low nibble
  task xfer(input rs, input rw, input [7:0] d);
    begin
      if (nib_q) begin
        strobe(rs, rw, {d[7:4], 4'h5});
        strobe(rs, rw, {d[3:0], 4'h5});
      end else begin
        strobe(rs, rw, d);
      end
      idle;
    end
  endtask
endmodule

// File: lcd_busy_timer.v
// lcd_busy_timer.v: down counter that holds the busy flag for a loaded span.
// assumes the caller loads a nonzero cycle count for one cycle per operation.
`timescale 1ns/1ps
module lcd_busy_timer #(
  parameter W = 20
) (
  input wire clk_i,
  input wire reset_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output wire busy_o
);
  reg [W-1:0] cnt_q; // cycles left in the current operation

  // reload on a new operation, otherwise count down to zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= {W{1'b0}};
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_q != {W{1'b0}});
endmodule

// File: lcd_cmd_regs.vh
// lcd_cmd_regs.vh: opcode positions, field bits, addresses and timing for the
// character display command interpreter.
// assumes inclusion by bare name from the design files of this folder.
`ifndef LCD_CMD_REGS_VH
`define LCD_CMD_REGS_VH

// timing figures in nanoseconds and the clock period
`define CLK_PERIOD_NS 25
`define T_LONG_NS 1520000
`define T_INSTR_NS 37000
`define T_DATA_NS 43000
`define T_POWERUP_NS 10000000

// character codes and addresses
`define SPACE_CODE 8'h20
`define ADDR_HOME 7'h00
`define ONE_LINE_LAST 7'h4F
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67

// field bit positions within an instruction byte
`define BIT_ID 1
`define BIT_SH 0
`define BIT_DISP 2
`define BIT_CUR 1
`define BIT_BLINK 0
`define BIT_SC 3
`define BIT_RL 2
`define BIT_DL 4
`define BIT_LINES 3
`define BIT_FONT 2

// opcode class, position of the highest set bit
`define OP_CLEAR 3'd0
`define OP_HOME 3'd1
`define OP_ENTRY 3'd2
`define OP_DISP 3'd3
`define OP_SHIFT 3'd4
`define OP_FUNC 3'd5
`define OP_GLYPH 3'd6
`define OP_DDADDR 3'd7

`endif

// File: lcd_props.sv
// lcd_props.sv: port checks for the display command interpreter.
// assumes a bind onto the top module; one clock, clk_i.
`timescale 1ns/1ps
module lcd_props (
  input wire clk_i,
  input wire reset_i,
  input wire register_select_i,
  input wire read_write_i,
  input wire enable_i,
  input wire data_oe_n_o,
  input wire busy_flag_o,
  input wire [6:0] memory_pointer_o,
  input wire display_on_o,
  input wire cursor_on_o,
  input wire blink_on_o,
  input wire [6:0] display_shift_o
);
  reg en_q;  // enable one edge back
  reg [1:0] age_q;  // edges since reset; hides the fill at release
  reg [16:0] bcnt_q;  // length of the running busy span
  wire taken = en_q & ~enable_i;  // strobe taken on this edge
  wire instr_wr = ~register_select_i & ~read_write_i;
  wire [9:0] modes = {display_on_o, cursor_on_o, blink_on_o, display_shift_o};
  // helper state
  always @(posedge clk_i) begin
    en_q <= enable_i & ~reset_i;
    age_q <= reset_i ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
    bcnt_q <= (busy_flag_o && !reset_i) ? bcnt_q + 17'h1 : 17'h0;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  property p_oe;
    data_oe_n_o == !(enable_i && read_write_i);
  endproperty
  a_oe: assert property (p_oe) else $error("read drive enable wrong");
  property p_busy_cause;
    $rose(busy_flag_o) && age_q == 2'h3 |-> $past(taken) || $past(taken, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without strobe");
  property p_ptr_cause;
    $changed(memory_pointer_o) && age_q == 2'h3 |-> $past(taken) || $past(taken, 2);
  endproperty
  a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved alone");
  property p_mode_cause;
    $changed(modes) && age_q == 2'h3 |-> $past(taken) || $past(taken, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved alone");
  property p_min_busy;
    $rose(busy_flag_o) |-> busy_flag_o [*8];
  endproperty
  a_min_busy: assert property (p_min_busy) else $error("busy too short");
  property p_max_busy;
    bcnt_q <= 17'h0ED80;
  endproperty
  a_max_busy: assert property (p_max_busy) else $error("busy too long");
  property p_refuse;
    taken && busy_flag_o && instr_wr |=> $stable(memory_pointer_o) [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy command obeyed");
  property p_stat;
    taken && !register_select_i && read_write_i && !busy_flag_o |=> !busy_flag_o [*2];
  endproperty
  a_stat: assert property (p_stat) else $error("status read set busy");
  c_refuse: cover property (taken && busy_flag_o && instr_wr);
  c_read: cover property (taken && register_select_i && read_write_i);
  c_shift: cover property ($changed(display_shift_o));
endmodule

// File: tb_top.sv
// tb_top.sv: self-checking bench for the display command interpreter.
// assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 1'b0;  // 40 MHz
  reg reset_i = 1'b1;
  wire rs, rw, en, oe_n, busy, d_on, c_on, b_on, two, tall;
  wire [7:0] di, dq;
  wire [6:0] ptr, sh;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  localparam integer PWR_NS = 5000;  // short power-up span keeps the run brief
  localparam integer PWR_SPAN = PWR_NS / 25;  // expected power-up busy cycles at 25 ns
  integer run = 0;  // busy span in progress
  integer last = 0;  // last finished busy span
  wire [7:0] rd = host_bfm_inst.rd_q;
  always #12.5 clk_i = ~clk_i;
  // span meter and hang guard; home alone costs 60800 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    run <= (busy === 1'b1 && !reset_i) ? run + 1 : 0;
    if (busy === 1'b0 && run != 0)
      last <= run;
    if (cyc == 100000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  char_lcd_instruction_decoder #(.POWERUP_NS(PWR_NS)) char_lcd_instruction_decoder_inst (
    .clk_i(clk_i),
    .reset_i(reset_i), .register_select_i(rs), .read_write_i(rw), .enable_i(en),
    .data_i(di), .data_o(dq), .data_oe_n_o(oe_n), .busy_flag_o(busy),
    .memory_pointer_o(ptr), .display_on_o(d_on), .cursor_on_o(c_on), .blink_on_o(b_on),
    .two_line_o(two), .font_tall_o(tall), .display_shift_o(sh));
  host_bfm host_bfm_inst (.clk_i(clk_i), .busy_i(busy), .rdata_i(dq),
    .register_select_o(rs), .read_write_o(rw), .enable_o(en), .data_o(di));
  task note(input ok);
    begin
      check_count = check_count + 1;
      if (!ok) begin
        error_cnt = error_cnt + 1;
        $display("BAD at %0t: mismatch", $time);
      end
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    note(got === exp);
  endtask
  task chkn(input integer got, input integer exp);
    note(got === exp);
  endtask
  // m is {select, read}
  task op(input [1:0] m, input [7:0] d);
    host_bfm_inst.xfer(m[1], m[0], d);
  endtask
  task t_reset;
    begin
      host_bfm_inst.idle;
      chkn(last, PWR_SPAN);
      chk({3'h0, d_on, c_on, b_on, two, tall}, 8'h00);
      op(2'h1, 8'h00);
      chk(rd, 8'h00);
      op(2'h3, 8'h00);
      chk(rd, 8'h20);
      chkn(last, 1720);
      op(2'h1, 8'h00);
      chk(rd, 8'h01);
      $display("reset test done");
    end
  endtask
  task t_addr;
    begin
      op(2'h0, 8'h3C);
      chk({6'h00, two, tall}, 8'h03);
      chkn(last, 1480);
      op(2'h0, 8'h0D);
      chk({5'h00, d_on, c_on, b_on}, 8'h05);
      op(2'h0, 8'hA7);
      chk(8'(ptr), 8'h27);
      op(2'h2, 8'h41);
      chk(8'(ptr), 8'h40);
      op(2'h0, 8'hA7);
      op(2'h3, 8'h00);
      chk(rd, 8'h41);
      $display("address test done");
    end
  endtask
  task t_entry;
    begin
      op(2'h0, 8'h04);
      op(2'h2, 8'h42);
      chk(8'(ptr), 8'h27);
      chk(8'(sh), 8'h00);
      op(2'h0, 8'h07);
      op(2'h2, 8'h43);
      chk(8'(ptr), 8'h40);
      chk(8'(sh), 8'h7F);
      $display("entry test done");
    end
  endtask
  task t_shift;
    begin
      host_bfm_inst.slow = 3;
      op(2'h0, 8'h14);
      chk(8'(ptr), 8'h41);
      op(2'h0, 8'h10);
      op(2'h0, 8'h1C);
      chk(8'(ptr), 8'h40);
      chk(8'(sh), 8'h00);
      host_bfm_inst.slow = 0;
      $display("shift test done");
    end
  endtask
  task t_glyph;
    begin
      op(2'h0, 8'h45);
      chk(8'(ptr), 8'h05);
      op(2'h2, 8'h1F);
      chk(8'(ptr), 8'h06);
      op(2'h0, 8'h45);
      op(2'h3, 8'h00);
      chk(rd, 8'h1F);
      $display("glyph test done");
    end
  endtask
  // second command lands while busy and must be dropped
  task t_refuse;
    begin
      host_bfm_inst.strobe(1'b0, 1'b0, 8'hB3);
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h91);
      host_bfm_inst.idle;
      chk(8'(ptr), 8'h33);
      $display("refuse test done");
    end
  endtask
  task t_nibble;
    begin
      // instruction init: three function sets with no poll between them
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h30);
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h30);
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h30);
      host_bfm_inst.idle;
      chk({6'h00, two, tall}, 8'h00);
      op(2'h0, 8'h28);
      host_bfm_inst.nib_q = 1'b1;
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h95);
      chk({7'h00, busy}, 8'h00);
      host_bfm_inst.strobe(1'b0, 1'b0, 8'h05);
      chk({7'h00, busy}, 8'h01);
      host_bfm_inst.idle;
      chk(8'(ptr), 8'h10);
      op(2'h1, 8'h00);
      chk(rd, 8'h00);
      $display("nibble test done");
    end
  endtask
  task t_home;
    begin
      op(2'h0, 8'h18);
      chk(8'(sh), 8'h7F);
      op(2'h0, 8'h02);
      chk(8'(ptr), 8'h00);
      chk(8'(sh), 8'h00);
      chkn(last, 60800);
      $display("home test done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    t_reset;
    t_addr;
    t_entry;
    t_shift;
    t_glyph;
    t_refuse;
    t_nibble;
    t_home;
    tally_and_finish;
  end
endmodule
bind char_lcd_instruction_decoder lcd_props lcd_props_inst (.clk_i, .reset_i,
  .register_select_i, .read_write_i, .enable_i, .data_oe_n_o, .busy_flag_o,
  .memory_pointer_o, .display_on_o, .cursor_on_o, .blink_on_o, .display_shift_o);
